/* File: src/lsd_regs.svh */
// Register offsets, field layouts and reset values of the link status / doorbell block.
// Assumes a 12-bit register byte offset within the port's register space.
`ifndef LSD_REGS_SVH
`define LSD_REGS_SVH

`define LSD_OFF_EVENT_MASK   12'h908
`define LSD_OFF_STATE_VEC    12'h90c
`define LSD_OFF_DOORBELL     12'h910
`define LSD_OFF_LINK_DOWN    12'h904
`define LSD_PORT_MASK        32'h00ff000f
`define LSD_EVENT_MASK_RST   32'h00ff000f
`define LSD_DOORBELL_MASK    32'h0000000f
`define LSD_DOORBELL_W       4

`endif

/* File: src/lsd_pkg.sv */
// Types shared by the link status / doorbell register files.
// Assumes lsd_regs.svh sits on the include path.
`default_nettype none
package lsd_pkg;
    typedef logic [31:0] lsd_word_t;
    typedef logic [11:0] lsd_addr_t;
    typedef enum logic { LSD_SRC_MGMT, LSD_SRC_VSW } lsd_src_t;
endpackage
`default_nettype wire

/* File: src/lsd_sync.sv */
// Two-stage synchroniser for the per-port data link state pins.
// Assumes the link state arrives asynchronously to sys_clk.
`default_nettype none
module lsd_sync (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // Data
    input  wire logic [31:0] asyncIn,
    output logic      [31:0] syncOut
);
    logic [31:0] stage1;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            stage1  <= 32'h0;
            syncOut <= 32'h0;
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule
`default_nettype wire

/* File: src/lsd_link_status_doorbell_regs.sv */
// Link event mask, link state vector, link-down flags and doorbell registers.
// Assumes a single-cycle register port; writes from both software sources share it.
//
// Function
// RULE1 - Mask bits 20..23 gate port link interrupts; 1 masks, reset 1, sticky.
// RULE2 - Mask bits 0..3 and 16..19 gate likewise; other bits reserved.
// RULE3 - State bits 0..3 show ports 0..3 data link active; reset 0.
// RULE4 - State bits 16..23 show ports 16..23 active; other bits read zero.
// RULE5 - A set mask bit suppresses that port's link interrupt.
// RULE6 - Link-down flag sets on active-to-inactive; cleared by writing one.
// RULE7 - Virtual switch upstream write of one sets doorbell bit and interrupts.
// RULE8 - Management write of one clears only those doorbell bits.
// RULE9 - Doorbell resets zero; bits 31..4 read zero, writes ignored.
// RULE10 - Interrupt is OR of unmasked pending link events and doorbells.
`include "lsd_regs.svh"
`default_nettype none
module lsd_link_status_doorbell_regs (
    // Clock and resets
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire logic              powerOnRst_b,
    // Register port
    input  wire logic              regWrite,
    input  wire logic              regRead,
    input  wire lsd_pkg::lsd_addr_t regAddr,
    input  wire lsd_pkg::lsd_word_t regWrData,
    input  wire lsd_pkg::lsd_src_t  regSrc,
    output lsd_pkg::lsd_word_t      regRdData,
    output logic                   regRdValid,
    // Link state pins
    input  wire logic [31:0]       dlActive,
    // Interrupt toward the management upstream port
    output logic                   mgmtIrq
);
    import lsd_pkg::*;

    // ----------------------------------------
    // Synchronised link state
    // ----------------------------------------
    lsd_word_t linkState;
    lsd_word_t prevState;
    logic [2:0] warmUp;
    // Sync stages hold zero just after reset; no edges until they carry real pins
    wire logic  stateValid = warmUp[2];

    lsd_sync u_sync (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .asyncIn (dlActive),
        .syncOut (linkState)
    );

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic logic hit(input lsd_addr_t a, input lsd_addr_t off);
        hit = (a == off);
    endfunction

    wire logic wrMask   = regWrite && hit(regAddr, `LSD_OFF_EVENT_MASK) && regSrc == LSD_SRC_MGMT;
    wire logic wrDown   = regWrite && hit(regAddr, `LSD_OFF_LINK_DOWN) && regSrc == LSD_SRC_MGMT;
    wire logic wrDbSet  = regWrite && hit(regAddr, `LSD_OFF_DOORBELL) && regSrc == LSD_SRC_VSW;
    wire logic wrDbClr  = regWrite && hit(regAddr, `LSD_OFF_DOORBELL) && regSrc == LSD_SRC_MGMT;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    lsd_word_t                  eventMask;
    lsd_word_t                  linkDown;
    logic [`LSD_DOORBELL_W-1:0] doorbell;

    wire lsd_word_t stateVec = linkState & `LSD_PORT_MASK;                     // [RULE3] [RULE4]
    wire lsd_word_t downEdge = prevState & ~linkState & {32{stateValid}} & `LSD_PORT_MASK;
    wire lsd_word_t upEdge   = ~prevState & linkState & {32{stateValid}} & `LSD_PORT_MASK;
    wire logic [`LSD_DOORBELL_W-1:0] dbWr = regWrData[`LSD_DOORBELL_W-1:0];

    wire lsd_word_t next_linkDown = (linkDown & ~(wrDown ? regWrData : 32'h0)) | downEdge; // [RULE6]
    wire logic [`LSD_DOORBELL_W-1:0] next_doorbell =
        (doorbell & ~(wrDbClr ? dbWr : 4'h0)) | (wrDbSet ? dbWr : 4'h0);       // [RULE7] [RULE8]

    // Mask is sticky: only a power-on reset restores it
    always_ff @(posedge sys_clk) begin
        if (!powerOnRst_b)
            eventMask <= `LSD_EVENT_MASK_RST;                                   // [RULE1]
        else if (wrMask)
            eventMask <= regWrData & `LSD_PORT_MASK;                            // [RULE1] [RULE2]
    end

    // Link-up events are pulses with no flag register; latched here so they are not lost
    lsd_word_t linkUp;
    wire lsd_word_t next_linkUp = (linkUp & ~(wrDown ? regWrData : 32'h0)) | upEdge;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            prevState  <= 32'h0;
            warmUp     <= 3'h0;
            linkDown   <= 32'h0;
            linkUp     <= 32'h0;
            doorbell   <= 4'h0;                                                 // [RULE9]
        end else begin
            prevState  <= linkState;
            warmUp     <= {warmUp[1:0], 1'b1};
            linkDown   <= next_linkDown & `LSD_PORT_MASK;
            linkUp     <= next_linkUp & `LSD_PORT_MASK;
            doorbell   <= next_doorbell;
        end
    end

    // ----------------------------------------
    // Interrupt
    // ----------------------------------------
    wire lsd_word_t linkPend = (linkDown | linkUp) & ~eventMask;                // [RULE5]
    wire logic      irqNext  = (|linkPend) || (|doorbell);                      // [RULE10]

    always_ff @(posedge sys_clk) begin
        if (!rst_b)
            mgmtIrq <= 1'b0;
        else
            mgmtIrq <= irqNext;
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    lsd_word_t rdMux;
    always_comb begin
        case (regAddr)
            `LSD_OFF_EVENT_MASK: rdMux = eventMask;
            `LSD_OFF_STATE_VEC:  rdMux = stateVec;                              // [RULE4]
            `LSD_OFF_DOORBELL:   rdMux = {28'h0, doorbell};                     // [RULE9]
            `LSD_OFF_LINK_DOWN:  rdMux = linkDown;
            default:             rdMux = 32'h0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            regRdData  <= 32'h0;
            regRdValid <= 1'b0;
        end else begin
            regRdData  <= regRead ? rdMux : 32'h0;
            regRdValid <= regRead;
        end
    end
endmodule
`default_nettype wire

/* File: tb/lsd_assertions.sv */
// Port checker for the link status / doorbell registers.
// Assumes lsd_pkg and lsd_regs.svh compile first.
`include "lsd_regs.svh"
`default_nettype none
module lsd_assertions (
    // Strobes and flags
    input wire logic sys_clk, rst_b, powerOnRst_b, regWrite, regRead, regRdValid, mgmtIrq,
    // Register port and pins
    input wire lsd_pkg::lsd_addr_t regAddr,
    input wire lsd_pkg::lsd_src_t  regSrc,
    input wire lsd_pkg::lsd_word_t regWrData, regRdData, dlActive
);
    import lsd_pkg::*;
    wire st = regRead && regAddr == `LSD_OFF_STATE_VEC;
    wire mk = regRead && regAddr == `LSD_OFF_EVENT_MASK;
    wire db = regAddr == `LSD_OFF_DOORBELL;
    wire ring = regWrite && db && regSrc == LSD_SRC_VSW && |regWrData[3:0];
    wire lsd_word_t lvl = dlActive & `LSD_PORT_MASK;
    wire lsd_word_t rsv = regRdData & ~`LSD_PORT_MASK;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    a_read_answer: assert property (regRead |=> regRdValid) else $error("no answer");
    a_state_rsvd: assert property (st |=> rsv == 0) else $error("state rsvd");
    a_mask_rsvd: assert property (mk |=> rsv == 0) else $error("mask rsvd");
    a_db_rsvd: assert property (regRead && db |=> regRdData[31:4] == 0) else $error("db");
    a_db_raise: assert property (ring |-> ##[1:3] mgmtIrq) else $error("no db irq");
    // Sync pipeline needs settled pins before a read can match
    a_state_follow: assert property (($stable(lvl) && $past(rst_b, 3)) [*3] ##0 st
        |=> regRdData == $past(lvl)) else $error("state wrong");
    a_irq_hold: assert property (mgmtIrq && !regWrite && !$past(regWrite) |=> mgmtIrq)
        else $error("irq dropped");
    a_irq_quiet: assert property ((!regWrite && $stable(lvl)) [*5] ##0 !mgmtIrq &&
        $past(rst_b, 8) |=> !mgmtIrq) else $error("irq rose");
endmodule
bind lsd_link_status_doorbell_regs lsd_assertions i_lsd_assertions (.*);
`default_nettype wire

/* File: tb/lsd_link_model.sv */
// Link partner model driving data link levels.
// Assumes commands change after a clock edge.
`include "lsd_regs.svh"
`default_nettype none
module lsd_link_model (
    input  wire logic        sys_clk,
    input  wire logic [31:0] linkCmd,
    output var  logic [31:0] dlActive = 32'h0
);
    timeunit 1ns; timeprecision 1ps;
    // Unused pins toggle, so no one may lean on them
    always @(posedge sys_clk) dlActive <= linkCmd & `LSD_PORT_MASK | ~dlActive & ~`LSD_PORT_MASK;
endmodule
`default_nettype wire

/* File: tb/lsd_link_status_doorbell_regs_tb.sv */
// Bench for the link status / doorbell registers.
// Assumes design, package and link model compile first.
`include "lsd_regs.svh"
`default_nettype none
module lsd_link_status_doorbell_regs_tb;
    timeunit 1ns; timeprecision 1ps;
    import lsd_pkg::*;
    localparam lsd_addr_t MK = `LSD_OFF_EVENT_MASK, DB = `LSD_OFF_DOORBELL;
    localparam lsd_src_t M = LSD_SRC_MGMT, V = LSD_SRC_VSW;
    logic sys_clk = 0, rst_b = 0, powerOnRst_b = 0, regWrite = 0, regRead = 0;
    logic regRdValid, mgmtIrq;
    lsd_addr_t regAddr = 0;
    lsd_src_t regSrc = M;
    lsd_word_t regWrData = 0, linkCmd = 0, regRdData, dlActive, d;
    int error_cnt = 0, comparisons = 0;
    always #4 sys_clk = ~sys_clk;
    lsd_link_model i_lsd_link_model (.*);
    lsd_link_status_doorbell_regs i_lsd_link_status_doorbell_regs (.*);
    task automatic chk(string n, lsd_word_t e, s);
        comparisons++;
        if (s !== e) begin error_cnt++; $display("MISMATCH %s expected %h seen %h", n, e, s); end
    endtask
    // One access; a read is judged on its answer cycle
    task automatic acc(logic w, lsd_src_t s, lsd_addr_t a, lsd_word_t v);
        @(posedge sys_clk);
        {regWrite, regRead, regAddr, regWrData} <= {w, !w, a, v};
        regSrc <= s;
        @(posedge sys_clk);
        {regWrite, regRead} <= 2'h0;
        #1;
        if (!w) chk("regRdData", v, regRdData);
        if (!w) chk("regRdValid", 1, regRdValid);
    endtask
    task automatic irq(logic e);
        repeat (8) @(posedge sys_clk);
        #1 chk("mgmtIrq", e, mgmtIrq);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin #100000; error_cnt++; stop_test(); end
    initial begin
        void'($urandom(32'h1238));
        repeat (8) @(posedge sys_clk);
        {rst_b, powerOnRst_b} <= 2'h3;
        acc(1, V, MK, 0);
        acc(0, M, MK, `LSD_EVENT_MASK_RST);
        acc(0, M, DB, 0);
        acc(0, M, 12'h0, 0);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            linkCmd <= $urandom;
            irq(0);
            acc(0, M, `LSD_OFF_STATE_VEC, linkCmd & `LSD_PORT_MASK);
        end
        d = $urandom | 32'h1;
        acc(1, V, DB, d);
        acc(0, V, DB, d & `LSD_DOORBELL_MASK);
        irq(1);
        acc(1, M, DB, 32'hfffffffe);
        acc(0, M, DB, 1);
        acc(1, M, DB, 1);
        irq(0);
        $display("link state and doorbell test done");
        linkCmd <= 0;
        acc(1, M, MK, 32'hffffffff);
        acc(0, M, MK, `LSD_PORT_MASK);
        acc(1, M, MK, 0);
        @(posedge sys_clk) rst_b <= 0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1;
        acc(0, M, MK, 0);
        linkCmd <= 32'h00100001;
        irq(1);
        linkCmd <= 0;
        irq(1);
        acc(0, M, `LSD_OFF_LINK_DOWN, 32'h00100001);
        acc(1, M, `LSD_OFF_LINK_DOWN, 32'h00100001);
        irq(0);
        $display("link event test done");
        stop_test();
    end
endmodule
`default_nettype wire
